// >>> hdl/training_command_decoder.sv
`timescale 1ns/1ns
// How it works
// (RQ1) operand: bit 6 first edge, rest second
// (RQ2) bit 6 clear means no operation
// (RQ3) controller issues follow-on column command immediately
// (RQ4) only fifo reads, fifo writes and calibration reads take follow-on
// (RQ5) latencies count from follow-on second edge
// (RQ6) controller drives follow-on operands low
// (RQ7) decode fifo read, calibration read, fifo write
// (RQ8) decode oscillator start/stop, impedance start/latch
// (RQ9) fifo bursts are always sixteen beats
// (RQ10) fifo write accepted in any state, clock-enable high
// (RQ11) back-to-back fifo commands run seamlessly
// (RQ12) fifo write captures at write latency
// (RQ13) fifo read drives at read latency
// (RQ14) five entries, sixth write overwrites first
// (RQ15) unwritten entries read back undefined
// (RQ16) read pointer advances and wraps after five
// (RQ17) clock-enable low and column commands disturb pointers
// (RQ18) mask/inversion pins driven when any enable set
// (RQ19) controller waits write-to-fifo-write interval
// (RQ20) controller waits read-training-to-read interval
// (RQ21) calibration read sends pattern a then b
// (RQ22) oscillator stop stores count low and high
// (RQ23) reserved codes change nothing; the decoder still counts them in rsv_cnt_ff
// (RQ24) write pointer restarts after a disturbance
module training_command_decoder import training_cmd_pkg::*; (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire ca_pins_t    pins_i,
	input  wire logic        col_disturb_i,
	input  wire logic [31:0] dq_i,
	input  wire logic [3:0]  dmi_i,
	output logic      [31:0] dq_o,
	output logic             dq_oe_o,
	output logic      [3:0]  dmi_o,
	output logic             dmi_oe_o,
	output logic             osc_run_o,
	output logic             zq_start_o,
	output logic             zq_latch_o
);
	logic       rst_s1_ff, rst_n;
	ca_pins_t   pin_s1_ff, pin_q_ff;
	beat_pair_t dat_s1_ff, dat_q_ff;

	// reset release and pin capture; pins and data share the same delay so they stay aligned
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_ff <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n     <= rst_s1_ff;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= '0;
			pin_q_ff  <= '0;
			dat_s1_ff <= '0;
			dat_q_ff  <= '0;
		end else begin
			pin_s1_ff <= pins_i;
			pin_q_ff  <= pin_s1_ff;
			dat_s1_ff <= {dmi_i, dq_i};
			dat_q_ff  <= dat_s1_ff;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	// configuration held in registers
	logic [4:0]  rl_ff, wl_ff;
	logic        winv_ff, rinv_ff, dm_ff;
	logic [7:0]  pat_a_ff, pat_b_ff;
	logic        err_clr;
	// decoder state
	dec_state_t  state_ff, nxt_state;
	col_kind_t   kind_ff, nxt_kind;
	logic        op6_ff, nxt_op6, disturbed_ff, nxt_disturbed, err_ff, nxt_err;
	logic [2:0]  wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr, wr_idx;
	logic        osc_run_ff, nxt_osc_run, zq_start_ff, nxt_zq_start, zq_latch_ff, nxt_zq_latch;
	logic [15:0] osc_cnt_ff, nxt_osc_cnt, osc_res_ff, nxt_osc_res;
	logic [7:0]  rsv_cnt_ff, nxt_rsv_cnt;
	token_t      wr_tok, rd_tok;
	logic [6:0]  op;
	logic        cas2_first;

	// command decode; a short or broken pair is dropped and flagged, never half executed
	always_comb begin
		nxt_state     = state_ff;
		nxt_kind      = kind_ff;
		nxt_op6       = op6_ff;
		nxt_wr_ptr    = wr_ptr_ff;
		nxt_rd_ptr    = rd_ptr_ff;
		nxt_osc_run   = osc_run_ff;
		nxt_osc_res   = osc_res_ff;
		nxt_rsv_cnt   = rsv_cnt_ff;
		nxt_zq_start  = 1'b0;
		nxt_zq_latch  = 1'b0;
		nxt_disturbed = disturbed_ff;
		wr_tok        = '0;
		rd_tok        = '0;
		wr_idx        = disturbed_ff ? 3'h0 : wr_ptr_ff;
		op            = {op6_ff, pin_q_ff.ca};                              // RQ1
		cas2_first    = pin_q_ff.cs && pin_q_ff.ca[4:0] == FIRST_CAS2;
		nxt_err       = err_ff && !err_clr;
		nxt_osc_cnt   = (osc_run_ff && osc_cnt_ff != OSC_MAX) ? osc_cnt_ff + 16'h0001 : osc_cnt_ff;
		case (state_ff)
			S_IDLE: begin
				// clock-enable high is the only gate: banks, refresh or self refresh do not matter
				if (pin_q_ff.cke && pin_q_ff.cs && pin_q_ff.ca[4:0] == FIRST_MPC) begin // RQ10
					nxt_op6   = pin_q_ff.ca[5];                                 // RQ1
					nxt_state = S_MPC2;
				end
			end
			S_MPC2: begin
				nxt_state = S_IDLE;
				if (pin_q_ff.cs) begin
					nxt_err = 1'b1;
				end else if (op6_ff) begin                                  // RQ2
					case (op)
						OP_WR_FIFO: begin                                   // RQ7
							nxt_kind  = K_WR;
							nxt_state = S_CAS1;                             // RQ4
						end
						OP_RD_FIFO: begin                                   // RQ7
							nxt_kind  = K_RD;
							nxt_state = S_CAS1;                             // RQ4
						end
						OP_RD_CAL: begin                                    // RQ7
							nxt_kind  = K_CAL;
							nxt_state = S_CAS1;                             // RQ4
						end
						OP_OSC_START: begin                                 // RQ8
							nxt_osc_run = 1'b1;
							nxt_osc_cnt = 16'h0000;
						end
						OP_OSC_STOP: begin                                  // RQ8
							nxt_osc_run = 1'b0;
							nxt_osc_res = osc_cnt_ff;                       // RQ22
						end
						OP_ZQ_START: nxt_zq_start = 1'b1;                   // RQ8
						OP_ZQ_LATCH: nxt_zq_latch = 1'b1;                   // RQ8
						default: nxt_rsv_cnt = (rsv_cnt_ff == 8'hFF) ? rsv_cnt_ff : rsv_cnt_ff + 8'h01; // RQ23
					endcase
				end
			end
			S_CAS1: begin
				// anything but the follow-on column command here abandons the training access
				if (cas2_first) begin                                       // RQ3
					nxt_state = S_CAS2;
				end else begin
					nxt_state = S_IDLE;
					nxt_err   = 1'b1;
				end
			end
			S_CAS2: begin
				nxt_state = S_IDLE;
				// follow-on operands are not checked; the controller holds them low
				if (pin_q_ff.cs) begin
					nxt_err = 1'b1;
				end else begin
					case (kind_ff)
						K_WR: begin
							wr_tok        = '{valid: 1'b1, cal: 1'b0, idx: wr_idx}; // RQ5
							nxt_wr_ptr    = (wr_idx == PTR_LAST) ? 3'h0 : wr_idx + 3'h1; // RQ14
							nxt_rd_ptr    = disturbed_ff ? 3'h0 : rd_ptr_ff; // RQ24
							nxt_disturbed = 1'b0;
						end
						K_RD: begin
							rd_tok     = '{valid: 1'b1, cal: 1'b0, idx: rd_ptr_ff}; // RQ5
							nxt_rd_ptr = (rd_ptr_ff == PTR_LAST) ? 3'h0 : rd_ptr_ff + 3'h1; // RQ16
						end
						K_CAL: begin
							rd_tok        = '{valid: 1'b1, cal: 1'b1, idx: 3'h0}; // RQ5
							nxt_disturbed = 1'b1;                           // RQ17
						end
						default: nxt_err = 1'b1;
					endcase
				end
			end
			default: nxt_state = S_IDLE;
		endcase
		// placed last so a disturbance in the same cycle as a fifo write is not lost
		if (!pin_q_ff.cke || col_disturb_i) begin
			nxt_disturbed = 1'b1;                                           // RQ17
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_ff     <= S_IDLE;
			kind_ff      <= K_NONE;
			op6_ff       <= 1'b0;
			wr_ptr_ff    <= 3'h0;
			rd_ptr_ff    <= 3'h0;
			disturbed_ff <= 1'b1;
			osc_run_ff   <= 1'b0;
			osc_cnt_ff   <= 16'h0000;
			osc_res_ff   <= 16'h0000;
			rsv_cnt_ff   <= 8'h00;
			zq_start_ff  <= 1'b0;
			zq_latch_ff  <= 1'b0;
			err_ff       <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			kind_ff      <= nxt_kind;
			op6_ff       <= nxt_op6;
			wr_ptr_ff    <= nxt_wr_ptr;
			rd_ptr_ff    <= nxt_rd_ptr;
			disturbed_ff <= nxt_disturbed;
			osc_run_ff   <= nxt_osc_run;
			osc_cnt_ff   <= nxt_osc_cnt;
			osc_res_ff   <= nxt_osc_res;
			rsv_cnt_ff   <= nxt_rsv_cnt;
			zq_start_ff  <= nxt_zq_start;
			zq_latch_ff  <= nxt_zq_latch;
			err_ff       <= nxt_err;
		end
	end

	assign osc_run_o  = osc_run_ff;
	assign zq_start_o = zq_start_ff;
	assign zq_latch_o = zq_latch_ff;

	// latency pipes; the 5-bit latency fields bound both latencies to 31 cycles, within the 32-stage depth
	token_t wr_pipe_ff [PIPE_DEPTH];
	token_t rd_pipe_ff [PIPE_DEPTH];
	token_t nxt_wr_pipe [PIPE_DEPTH];
	token_t nxt_rd_pipe [PIPE_DEPTH];
	token_t wr_tap, rd_tap;
	logic [4:0] wl_tap, rl_tap;

	always_comb begin
		nxt_wr_pipe[0] = wr_tok;
		nxt_rd_pipe[0] = rd_tok;
		for (int i = 1; i < PIPE_DEPTH; i++) begin
			nxt_wr_pipe[i] = wr_pipe_ff[i-1];
			nxt_rd_pipe[i] = rd_pipe_ff[i-1];
		end
		// write taps one stage later than read because read data leave through an output flop
		wl_tap = (wl_ff == 5'h00) ? 5'h00 : wl_ff - 5'h01;                  // RQ12
		rl_tap = (rl_ff < 5'h02) ? 5'h00 : rl_ff - 5'h02;                  // RQ13
		wr_tap = wr_pipe_ff[wl_tap];
		rd_tap = rd_pipe_ff[rl_tap];
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			wr_pipe_ff <= '{default: '0};
			rd_pipe_ff <= '{default: '0};
		end else begin
			wr_pipe_ff <= nxt_wr_pipe;
			rd_pipe_ff <= nxt_rd_pipe;
		end
	end

	// burst engines and training fifo; entries never written keep whatever they held
	beat_pair_t mem_ff [FIFO_DEPTH][BURST_CYCLES];
	beat_pair_t nxt_mem [FIFO_DEPTH][BURST_CYCLES];
	logic       wact_ff, nxt_wact, ract_ff, nxt_ract, rcal_ff, nxt_rcal, w_on, r_on, r_cal;
	logic [2:0] wbeat_ff, nxt_wbeat, widx_ff, nxt_widx, rbeat_ff, nxt_rbeat, ridx_ff, nxt_ridx;
	logic [2:0] w_beat, w_idx, r_beat, r_idx;
	logic [15:0] pat16;
	logic        rise_bit, fall_bit;
	logic [31:0] nxt_dq;
	logic [3:0]  nxt_dmi;
	logic        nxt_dq_oe, nxt_dmi_oe;

	always_comb begin
		nxt_mem   = mem_ff;
		// a new token restarts the count, so bursts at the column interval join seamlessly
		w_on      = wr_tap.valid || wact_ff;                                // RQ11
		w_idx     = wr_tap.valid ? wr_tap.idx : widx_ff;
		w_beat    = wr_tap.valid ? 3'h0 : wbeat_ff;
		r_on      = rd_tap.valid || ract_ff;                                // RQ11
		r_idx     = rd_tap.valid ? rd_tap.idx : ridx_ff;
		r_cal     = rd_tap.valid ? rd_tap.cal : rcal_ff;
		r_beat    = rd_tap.valid ? 3'h0 : rbeat_ff;
		// burst length configuration is not consulted: always eight clocks
		nxt_wact  = w_on && w_beat != BEAT_LAST;                            // RQ9
		nxt_ract  = r_on && r_beat != BEAT_LAST;                            // RQ9
		nxt_wbeat = w_beat + 3'h1;
		nxt_rbeat = r_beat + 3'h1;
		nxt_widx  = w_idx;
		nxt_ridx  = r_idx;
		nxt_rcal  = r_cal;
		if (w_on) begin
			nxt_mem[w_idx][w_beat] = dat_q_ff;                              // RQ12 RQ14
		end
		pat16    = {pat_b_ff, pat_a_ff};
		rise_bit = pat16[{r_beat, 1'b0}];                                   // RQ21
		fall_bit = pat16[{r_beat, 1'b1}];
		nxt_dq     = 32'h0000_0000;
		nxt_dmi    = 4'h0;
		nxt_dq_oe  = r_on;
		nxt_dmi_oe = 1'b0;
		if (r_on && r_cal) begin
			// pattern goes on every pin, mask pins too, with no inversion applied
			nxt_dq     = {{16{fall_bit}}, {16{rise_bit}}};                  // RQ21
			nxt_dmi    = {fall_bit, fall_bit, rise_bit, rise_bit};
			nxt_dmi_oe = 1'b1;
		end else if (r_on) begin
			nxt_dq     = mem_ff[r_idx][r_beat].dq;                          // RQ13 RQ15
			nxt_dmi    = mem_ff[r_idx][r_beat].mask_inversion_pins;
			nxt_dmi_oe = winv_ff || rinv_ff || dm_ff;                       // RQ18
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			mem_ff   <= '{default: '{default: '0}};
			wact_ff  <= 1'b0;
			ract_ff  <= 1'b0;
			rcal_ff  <= 1'b0;
			wbeat_ff <= 3'h0;
			rbeat_ff <= 3'h0;
			widx_ff  <= 3'h0;
			ridx_ff  <= 3'h0;
			dq_o     <= 32'h0000_0000;
			dmi_o    <= 4'h0;
			dq_oe_o  <= 1'b0;
			dmi_oe_o <= 1'b0;
		end else begin
			mem_ff   <= nxt_mem;
			wact_ff  <= nxt_wact;
			ract_ff  <= nxt_ract;
			rcal_ff  <= nxt_rcal;
			wbeat_ff <= nxt_wbeat;
			rbeat_ff <= nxt_rbeat;
			widx_ff  <= nxt_widx;
			ridx_ff  <= nxt_ridx;
			dq_o     <= nxt_dq;
			dmi_o    <= nxt_dmi;
			dq_oe_o  <= nxt_dq_oe;
			dmi_oe_o <= nxt_dmi_oe;
		end
	end

	// apb slave, zero wait; read data and error are set up in the setup phase
	logic [31:0] nxt_prdata, rd_word;
	logic        nxt_perr, mapped, wr_acc, perr_ff;
	logic [4:0]  nxt_rl, nxt_wl;
	logic        nxt_winv, nxt_rinv, nxt_dm;
	logic [7:0]  nxt_pat_a, nxt_pat_b;

	always_comb begin
		mapped  = 1'b1;
		rd_word = 32'h0000_0000;
		case (paddr_i)
			REG_CFG: begin
				rd_word[CFG_RL_LSB +: 5] = rl_ff;
				rd_word[CFG_WL_LSB +: 5] = wl_ff;
				rd_word[CFG_WINV_BIT]    = winv_ff;
				rd_word[CFG_RINV_BIT]    = rinv_ff;
				rd_word[CFG_DM_BIT]      = dm_ff;
			end
			REG_PATTERN: rd_word[15:0] = {pat_b_ff, pat_a_ff};
			REG_OSC:     rd_word[15:0] = osc_res_ff;                        // RQ22
			REG_STATUS: begin
				rd_word[ST_WPTR_LSB +: 3] = wr_ptr_ff;
				rd_word[ST_RPTR_LSB +: 3] = rd_ptr_ff;
				rd_word[ST_OSC_BIT]       = osc_run_ff;
				rd_word[ST_ERR_BIT]       = err_ff;
				rd_word[ST_RSV_LSB +: 8]  = rsv_cnt_ff;
			end
			default: mapped = 1'b0;
		endcase
		wr_acc     = psel_i && penable_i && pwrite_i;
		nxt_prdata = (psel_i && !penable_i) ? rd_word : prdata_o;
		nxt_perr   = (psel_i && !penable_i) ? !mapped : perr_ff;
		err_clr    = wr_acc && paddr_i == REG_STATUS && pwdata_i[ST_ERR_BIT];
		nxt_rl     = rl_ff;
		nxt_wl     = wl_ff;
		nxt_winv   = winv_ff;
		nxt_rinv   = rinv_ff;
		nxt_dm     = dm_ff;
		nxt_pat_a  = pat_a_ff;
		nxt_pat_b  = pat_b_ff;
		if (wr_acc && paddr_i == REG_CFG) begin
			nxt_rl   = pwdata_i[CFG_RL_LSB +: 5];
			nxt_wl   = pwdata_i[CFG_WL_LSB +: 5];
			nxt_winv = pwdata_i[CFG_WINV_BIT];
			nxt_rinv = pwdata_i[CFG_RINV_BIT];
			nxt_dm   = pwdata_i[CFG_DM_BIT];
		end
		if (wr_acc && paddr_i == REG_PATTERN) begin
			nxt_pat_a = pwdata_i[7:0];
			nxt_pat_b = pwdata_i[PAT_B_LSB +: 8];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= 32'h0000_0000;
			perr_ff  <= 1'b0;
			rl_ff    <= RL_RESET;
			wl_ff    <= WL_RESET;
			winv_ff  <= 1'b0;
			rinv_ff  <= 1'b0;
			dm_ff    <= 1'b0;
			pat_a_ff <= PAT_A_RESET;
			pat_b_ff <= PAT_B_RESET;
		end else begin
			prdata_o <= nxt_prdata;
			perr_ff  <= nxt_perr;
			rl_ff    <= nxt_rl;
			wl_ff    <= nxt_wl;
			winv_ff  <= nxt_winv;
			rinv_ff  <= nxt_rinv;
			dm_ff    <= nxt_dm;
			pat_a_ff <= nxt_pat_a;
			pat_b_ff <= nxt_pat_b;
		end
	end

	assign pready_o  = 1'b1;
	assign pslverr_o = perr_ff && psel_i && penable_i;

	// checks on the decoder and burst engines
	sequence second_edge_s;
		state_ff == S_MPC2 && !pin_q_ff.cs && op6_ff;
	endsequence
	sequence fifo_wr_exec_s;
		state_ff == S_CAS2 && !pin_q_ff.cs && kind_ff == K_WR;
	endsequence

	nop_quiet_a: assert property ((state_ff == S_MPC2 && !pin_q_ff.cs && !op6_ff) |=> // RQ2
		(state_ff == S_IDLE && !zq_start_o && !zq_latch_o && $stable(osc_run_ff))) else $error("nop changed state");
	wr_decode_a: assert property ((second_edge_s and (op == OP_WR_FIFO)) |=> // RQ7
		(state_ff == S_CAS1 && kind_ff == K_WR)) else $error("fifo write not decoded");
	cas_follow_a: assert property ((state_ff == S_CAS1 && !cas2_first) |=> // RQ4
		(state_ff == S_IDLE && err_ff)) else $error("missing follow-on not flagged");
	zq_pulse_a: assert property ((second_edge_s and (op == OP_ZQ_START)) |=> // RQ8
		zq_start_o ##1 !zq_start_o) else $error("impedance start pulse wrong");
	osc_stop_a: assert property ((second_edge_s and (op == OP_OSC_STOP)) |=> // RQ22
		(!osc_run_ff && osc_res_ff == $past(osc_cnt_ff))) else $error("oscillator result not stored");
	reserved_a: assert property ((second_edge_s and (op == 7'h45 || op == 7'h49)) |=> // RQ23
		($stable(wr_ptr_ff) && $stable(rd_ptr_ff) && $stable(osc_run_ff))) else $error("reserved code had effect");
	ptr_wrap_a: assert property ((fifo_wr_exec_s and (!disturbed_ff && wr_ptr_ff == PTR_LAST)) |=> // RQ14
		wr_ptr_ff == 3'h0) else $error("sixth write did not reuse first entry");
	ptr_restart_a: assert property ((fifo_wr_exec_s and disturbed_ff) |=> // RQ24
		(wr_ptr_ff == 3'h1 && rd_ptr_ff == 3'h0)) else $error("pointers not restarted");
	burst_len_a: assert property ((wr_tap.valid && !wact_ff) |=> // RQ9
		(wact_ff && wbeat_ff == 3'h1) ##6 (wbeat_ff == BEAT_LAST) ##1 !wact_ff) else $error("write burst not eight clocks");
	dmi_drive_a: assert property ((rd_tap.valid && !rd_tap.cal && (winv_ff || rinv_ff || dm_ff)) |=> // RQ18
		(dmi_oe_o && dq_oe_o)) else $error("mask pins not driven");
	cal_pattern_a: assert property ((rd_tap.valid && rd_tap.cal) |=> // RQ21
		(dq_o[0] == $past(pat_a_ff[0]) && dq_o[16] == $past(pat_a_ff[1]))) else $error("calibration pattern wrong");
endmodule // training_command_decoder

// >>> hdl/training_cmd_pkg.sv
package training_cmd_pkg;
	// operand codes of the two-edge training command
	localparam logic [6:0] OP_RD_FIFO   = 7'h41;
	localparam logic [6:0] OP_RD_CAL    = 7'h43;
	localparam logic [6:0] OP_WR_FIFO   = 7'h47;
	localparam logic [6:0] OP_OSC_START = 7'h4B;
	localparam logic [6:0] OP_OSC_STOP  = 7'h4D;
	localparam logic [6:0] OP_ZQ_START  = 7'h4F;
	localparam logic [6:0] OP_ZQ_LATCH  = 7'h51;
	// first-edge patterns on ca[4:0] with chip select high
	localparam logic [4:0] FIRST_MPC    = 5'h00;
	localparam logic [4:0] FIRST_CAS2   = 5'h12;
	// fifo and burst geometry: BL16 is two beats per clock for eight clocks
	localparam int         FIFO_DEPTH   = 5;
	localparam int         BURST_CYCLES = 8;
	localparam int         PIPE_DEPTH   = 32;
	localparam logic [2:0] PTR_LAST     = 3'h4;
	localparam logic [2:0] BEAT_LAST    = 3'h7;
	localparam logic [15:0] OSC_MAX     = 16'hFFFF;
	// apb register byte offsets
	localparam logic [7:0] REG_CFG      = 8'h00;
	localparam logic [7:0] REG_PATTERN  = 8'h04;
	localparam logic [7:0] REG_OSC      = 8'h08;
	localparam logic [7:0] REG_STATUS   = 8'h0C;
	// field positions
	localparam int         CFG_RL_LSB   = 0;
	localparam int         CFG_WL_LSB   = 8;
	localparam int         CFG_WINV_BIT = 16;
	localparam int         CFG_RINV_BIT = 17;
	localparam int         CFG_DM_BIT   = 18;
	localparam int         PAT_B_LSB    = 8;
	localparam int         ST_WPTR_LSB  = 0;
	localparam int         ST_RPTR_LSB  = 4;
	localparam int         ST_OSC_BIT   = 8;
	localparam int         ST_ERR_BIT   = 9;
	localparam int         ST_RSV_LSB   = 16;
	// values after reset
	localparam logic [4:0] RL_RESET     = 5'h0E;
	localparam logic [4:0] WL_RESET     = 5'h08;
	localparam logic [7:0] PAT_A_RESET  = 8'h00;
	localparam logic [7:0] PAT_B_RESET  = 8'h00;

	typedef enum logic [1:0] {S_IDLE, S_MPC2, S_CAS1, S_CAS2} dec_state_t;
	typedef enum logic [1:0] {K_NONE, K_WR, K_RD, K_CAL} col_kind_t;
	typedef struct packed {logic cke; logic cs; logic [5:0] ca;} ca_pins_t;
	typedef struct packed {logic valid; logic cal; logic [2:0] idx;} token_t;
	typedef struct packed {logic [3:0] mask_inversion_pins; logic [31:0] dq;} beat_pair_t;
endpackage

// >>> tb/ctrl_model.sv
`timescale 1ns/1ns
// controller side: command pins plus scheduled write data; idle data toggles so stale values never match
module ctrl_model import training_cmd_pkg::*; (
	input  wire logic   clk_i,
	output ca_pins_t    pins_o,
	output logic [31:0] dq_o,
	output logic [3:0]  dmi_o
);
	int          cyc;
	logic [35:0] sched [int];
	function automatic logic [31:0] pat(input logic [7:0] k, input int b);
		return {k, 8'(b), k ^ 8'h5A, 8'(b) ^ 8'hA5};
	endfunction
	initial begin
		cyc = 0;
		pins_o = '{1'b1, 1'b0, 6'h2A};
		{dmi_o, dq_o} = 36'h0;
	end
	// data lines follow the schedule, else show the inverse of the last value
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		{dmi_o, dq_o} <= sched.exists(cyc + 1) ? sched[cyc + 1] : ~{dmi_o, dq_o};
	end
	// a write burst is sixteen beats, one rise/fall pair per clock
	task automatic put(input int t, input logic [7:0] k);
		for (int b = 0; b < BURST_CYCLES; b++) begin
			sched[t + b] = {4'(b), pat(k, b)};
		end
	endtask
	// two-edge command, then the column follow-on right behind it when follow is set
	task automatic cmd(input logic [6:0] op, input bit follow);
		@(posedge clk_i) pins_o <= '{1'b1, 1'b1, {op[6], FIRST_MPC}};
		@(posedge clk_i) pins_o <= '{1'b1, 1'b0, op[5:0]};
		if (follow) begin
			@(posedge clk_i) pins_o <= '{1'b1, 1'b1, {1'b0, FIRST_CAS2}};
			@(posedge clk_i) pins_o <= '{1'b1, 1'b0, 6'h00};
		end
		@(posedge clk_i) pins_o <= '{1'b1, 1'b0, ~pins_o.ca};
	endtask
endmodule // ctrl_model

// >>> tb/training_command_decoder_test.sv
`timescale 1ns/1ns
module training_command_decoder_test import training_cmd_pkg::*;;
	logic mclk_i, resetn_i, psel_i, penable_i, pwrite_i, col_disturb_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, dq_i, dq_o, v;
	logic [3:0]  dmi_i, dmi_o;
	logic        pready_o, pslverr_o, dq_oe_o, dmi_oe_o, osc_run_o, zq_start_o, zq_latch_o;
	ca_pins_t    pins_i;
	int          fail_count, checks, zqs, zql;
	training_command_decoder training_command_decoder_i (.*);
	ctrl_model ctrl_model_i (.clk_i(mclk_i), .pins_o(pins_i), .dq_o(dq_i), .dmi_o(dmi_i));
	// 8 ns clock and pulse counters
	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		zqs <= zqs + 32'(zq_start_o);
		zql <= zql + 32'(zq_latch_o);
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one setup and one access phase, request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i) penable_i <= 1'b1;
		do @(posedge mclk_i); while (pready_o !== 1'b1);
		v = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		logic e;
		apb(1'b0, a, 32'h0, e);
		chk({3'h0, e, v}, {3'h0, eerr, exp});
	endtask
	// expected {mask pins, data pins} of one clock of a read burst
	function automatic logic [35:0] ex(input logic [7:0] k, input int b);
		logic [15:0] w;
		w = 16'h3C96;
		if (k == 8'hFF) begin
			return {w[2 * b + 1], w[2 * b + 1], w[2 * b], w[2 * b], {16{w[2 * b + 1]}}, {16{w[2 * b]}}};
		end
		return {4'(b), ctrl_model_i.pat(k, b)};
	endfunction
	// read bursts appear read latency after the follow-on, eight clocks long
	task automatic see(input int t, input logic [7:0] k);
		logic [35:0] x;
		for (int b = 0; b < BURST_CYCLES; b++) begin
			do @(posedge mclk_i); while (ctrl_model_i.cyc != t + b);
			x = ex(k, b);
			chk({dmi_oe_o, dq_oe_o, 2'h0, dq_o}, {4'hC, x[31:0]});
			chk({32'h0, dmi_o}, {32'h0, x[35:32]});
		end
	endtask
	// one command every column interval; k names the data of a burst
	task automatic op(input logic [6:0] code, input logic [7:0] k);
		int t;
		t = ctrl_model_i.cyc;
		if (code == OP_WR_FIFO) begin
			ctrl_model_i.put(t + 13, k);
		end else if (k != 8'h00) begin
			fork
				see(t + 21, k);
			join_none
		end
		ctrl_model_i.cmd(code, k != 8'h00);
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic end_of_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// watchdog far beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge mclk_i);
		fail_count++;
		end_of_test();
	end
	initial begin
		logic e;
		{mclk_i, resetn_i, psel_i, penable_i, pwrite_i, col_disturb_i} = 6'h00;
		{paddr_i, pwdata_i, fail_count, checks, zqs, zql} = '0;
		repeat (12) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		rd(REG_CFG, 32'(RL_RESET) | (32'(WL_RESET) << CFG_WL_LSB), 1'b0);
		rd(REG_STATUS, 32'h0, 1'b0);
		rd(8'h10, 32'h0, 1'b1);
		apb(1'b1, REG_CFG, 32'h0004080E, e);
		apb(1'b1, REG_PATTERN, 32'h00003C96, e);
		rd(REG_PATTERN, 32'h00003C96, 1'b0);
		$display("register test done");
		for (int k = 1; k <= 6; k++) op(OP_WR_FIFO, 8'(k));
		repeat (20) @(posedge mclk_i);
		rd(REG_STATUS, 32'h1, 1'b0);
		for (int i = 0; i < 6; i++) op(OP_RD_FIFO, (i == 0 || i == 5) ? 8'h06 : 8'(i + 1));
		repeat (30) @(posedge mclk_i);
		$display("fifo test done");
		col_disturb_i <= 1'b1;
		@(posedge mclk_i) col_disturb_i <= 1'b0;
		repeat (24) @(posedge mclk_i);
		op(OP_WR_FIFO, 8'h09);
		repeat (20) @(posedge mclk_i);
		op(OP_RD_FIFO, 8'h09);
		repeat (30) @(posedge mclk_i);
		$display("disturb test done");
		op(OP_ZQ_START, 8'h00);
		op(OP_ZQ_LATCH, 8'h00);
		op(7'h07, 8'h00);
		op(7'h45, 8'h00);
		op(7'h49, 8'h00);
		op(7'h53, 8'h00);
		op(OP_OSC_START, 8'h00);
		repeat (10) @(posedge mclk_i);
		chk(36'(osc_run_o), 36'h1);
		op(OP_OSC_STOP, 8'h00);
		repeat (6) @(posedge mclk_i);
		chk(36'(osc_run_o), 36'h0);
		chk({zqs[17:0], zql[17:0]}, {18'h1, 18'h1});
		op(OP_RD_FIFO, 8'h00);
		rd(REG_STATUS, 32'h00030211, 1'b0);
		apb(1'b1, REG_STATUS, 32'h00000200, e);
		rd(REG_STATUS, 32'h00030011, 1'b0);
		apb(1'b0, REG_OSC, 32'h0, e);
		chk(36'(v != 32'h0), 36'h1);
		$display("command test done");
		op(OP_RD_CAL, 8'hFF);
		repeat (30) @(posedge mclk_i);
		$display("calibration test done");
		end_of_test();
	end
endmodule // training_command_decoder_test
